// ==== shared/fpt_pkg.sv ====
/*
 * Constants and carrier types for the frequency protection trip logic.
 * Assumes one 50 MHz function clock and signed fixed-point measurement inputs.
 */
package fpt_pkg;
	// ----------------------------------------------------------------
	// Settings encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_UNDER = 3'h1;
	localparam logic [2:0] MODE_OVER = 3'h2;
	localparam logic [2:0] MODE_GRAD = 3'h3;
	localparam logic [2:0] MODE_UNDER_THEN_GRAD = 3'h4;
	localparam logic [2:0] MODE_OVER_THEN_GRAD = 3'h5;
	localparam logic [2:0] MODE_UNDER_OR_GRAD = 3'h6;
	localparam logic [2:0] MODE_OVER_OR_GRAD = 3'h7;
	localparam logic [2:0] MODE_RESET = MODE_UNDER;
	localparam logic [2:0] OPER_ENABLE = 3'h1;
	localparam logic [2:0] OPER_DISABLE = 3'h5;
	localparam logic [1:0] BLK_FREEZE = 2'h0;
	localparam logic [1:0] BLK_ALL = 2'h1;
	localparam logic [1:0] BLK_TRIP = 2'h2;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TW = 18;
	localparam logic [6:0] PCT_FULL = 7'h64;
	typedef logic [TW-1:0] fpt_ms_t;
	typedef struct packed {
		logic under;
		logic over;
		logic grad;
	} fpt_flags_t;
	typedef struct packed {
		logic [6:0] combined;
		logic [6:0] under;
		logic [6:0] over;
		logic [6:0] grad;
	} fpt_pct_t;
endpackage

// ==== design/fpt_trip_logic.sv ====
/*
 * Operate, timing, pickup-duration and blocking logic of the frequency protection.
 * Assumes measurement values and settings are synchronous to CORE_CLK_I.
 */
`timescale 1ns/100ps
module fpt_trip_logic import fpt_pkg::*; #(
	parameter int FW = 16,
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	// Measurements
	input wire logic signed [FW-1:0] FREQUENCY_IN_I,
	input wire logic signed [FW-1:0] FREQUENCY_GRADIENT_IN_I,
	// Settings
	input wire logic [2:0] OPERATION_I,
	input wire logic [2:0] TRIP_MODE_I,
	input wire logic [1:0] BLOCKING_MODE_I,
	input wire logic signed [FW-1:0] OVERFREQ_PICKUP_I,
	input wire logic signed [FW-1:0] UNDERFREQ_PICKUP_I,
	input wire logic signed [FW-1:0] GRADIENT_PICKUP_I,
	input wire logic [TW-1:0] FREQUENCY_TRIP_DELAY_I,
	input wire logic [TW-1:0] GRADIENT_TRIP_DELAY_I,
	input wire logic [TW-1:0] FREQUENCY_RESET_DELAY_I,
	input wire logic [TW-1:0] GRADIENT_RESET_DELAY_I,
	// Block input
	input wire logic BLOCK_I,
	// Outputs
	output logic PICKUP_O,
	output fpt_flags_t PICKUP_FLAGS_O,
	output logic TRIP_O,
	output fpt_flags_t TRIP_FLAGS_O,
	output fpt_pct_t PICKUP_PERCENT_O
);
	// ----------------------------------------------------------------
	// Mode decode and criteria
	// ----------------------------------------------------------------
	logic active;
	logic blk;
	logic freeze;
	logic use_freq;
	logic use_grad;
	logic freq_is_over;
	logic freq_crit;
	logic grad_crit;
	logic over_hit;
	logic grad_hit;
	logic tick;
	logic [$clog2(TICK_DIV)-1:0] div;

	// Undriven block input is expected to be tied low, so it reads inactive.
	assign blk = BLOCK_I;
	assign active = (OPERATION_I == OPER_ENABLE) && !(blk && BLOCKING_MODE_I == BLK_ALL);
	assign freeze = blk && BLOCKING_MODE_I == BLK_FREEZE;
	assign freq_is_over = TRIP_MODE_I == MODE_OVER || TRIP_MODE_I == MODE_OVER_OR_GRAD;
	assign use_freq = TRIP_MODE_I == MODE_UNDER || TRIP_MODE_I == MODE_OVER ||
		TRIP_MODE_I == MODE_UNDER_OR_GRAD || TRIP_MODE_I == MODE_OVER_OR_GRAD;
	assign use_grad = TRIP_MODE_I >= MODE_GRAD;
	assign over_hit = FREQUENCY_IN_I > OVERFREQ_PICKUP_I;

	// Sign of the gradient setting selects rising or falling protection.
	assign grad_hit = GRADIENT_PICKUP_I[FW-1] ? (FREQUENCY_GRADIENT_IN_I < GRADIENT_PICKUP_I) :
		(FREQUENCY_GRADIENT_IN_I > GRADIENT_PICKUP_I);
	assign freq_crit = use_freq && (freq_is_over ? over_hit : FREQUENCY_IN_I < UNDERFREQ_PICKUP_I);
	always_comb begin
		grad_crit = use_grad && grad_hit;
		if (TRIP_MODE_I == MODE_OVER_THEN_GRAD) begin
			grad_crit = over_hit && grad_hit;
		end else if (TRIP_MODE_I == MODE_UNDER_THEN_GRAD) begin
			grad_crit = FREQUENCY_IN_I < UNDERFREQ_PICKUP_I && grad_hit;
		end
	end

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	assign tick = div == ($clog2(TICK_DIV))'(TICK_DIV - 1);
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			div <= '0;
		end else if (tick) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Per-criterion definite-time stages
	// ----------------------------------------------------------------
	logic f_pick;
	logic g_pick;
	logic f_trip;
	logic g_trip;
	fpt_ms_t f_op;
	fpt_ms_t g_op;
	fpt_ms_t f_rst;
	fpt_ms_t g_rst;

	function automatic fpt_ms_t sat_inc(input fpt_ms_t v, input fpt_ms_t lim);
		sat_inc = (v >= lim) ? lim : v + 1'b1;
	endfunction

	function automatic logic [6:0] pct(input fpt_ms_t t, input fpt_ms_t d);
		logic [TW+6:0] p;
		p = '0;
		if (d == '0) begin
			pct = PCT_FULL;
		end else begin
			p = ((TW+7)'(t) * (TW+7)'(PCT_FULL)) / (TW+7)'(d);
			pct = (p > (TW+7)'(PCT_FULL)) ? PCT_FULL : p[6:0];
		end
	endfunction

	// Frequency stage: pickup, operate timer, reset timer, trip that clears as soon as the criterion drops.
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			f_pick <= 1'b0;
			f_op <= '0;
			f_rst <= '0;
			f_trip <= 1'b0;
		end else if (!active) begin
			f_pick <= 1'b0;
			f_op <= '0;
			f_rst <= '0;
			f_trip <= 1'b0;
		end else if (freeze) begin
			f_pick <= f_pick;
		end else if (freq_crit) begin
			f_pick <= 1'b1;
			f_rst <= '0;
			if (tick) begin
				f_op <= sat_inc(f_op, FREQUENCY_TRIP_DELAY_I);
			end
			f_trip <= f_op >= FREQUENCY_TRIP_DELAY_I;
		end else begin
			f_trip <= 1'b0;
			if (f_pick) begin
				if (f_rst >= FREQUENCY_RESET_DELAY_I) begin
					f_pick <= 1'b0;
					f_op <= '0;
					f_rst <= '0;
				end else if (tick) begin
					f_rst <= f_rst + 1'b1;
				end
			end
		end
	end

	// Gradient stage, same structure with its own delays.
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			g_pick <= 1'b0;
			g_op <= '0;
			g_rst <= '0;
			g_trip <= 1'b0;
		end else if (!active) begin
			g_pick <= 1'b0;
			g_op <= '0;
			g_rst <= '0;
			g_trip <= 1'b0;
		end else if (freeze) begin
			g_pick <= g_pick;
		end else if (grad_crit) begin
			g_pick <= 1'b1;
			g_rst <= '0;
			if (tick) begin
				g_op <= sat_inc(g_op, GRADIENT_TRIP_DELAY_I);
			end
			g_trip <= g_op >= GRADIENT_TRIP_DELAY_I;
		end else begin
			g_trip <= 1'b0;
			if (g_pick) begin
				if (g_rst >= GRADIENT_RESET_DELAY_I) begin
					g_pick <= 1'b0;
					g_op <= '0;
					g_rst <= '0;
				end else if (tick) begin
					g_rst <= g_rst + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic trip_gate;
	logic [6:0] pf;
	logic [6:0] pg;
	assign trip_gate = !(blk && BLOCKING_MODE_I == BLK_TRIP);
	assign pf = f_pick ? pct(f_op, FREQUENCY_TRIP_DELAY_I) : 7'h00;
	assign pg = g_pick ? pct(g_op, GRADIENT_TRIP_DELAY_I) : 7'h00;

	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PICKUP_O <= 1'b0;
			PICKUP_FLAGS_O <= '0;
			TRIP_O <= 1'b0;
			TRIP_FLAGS_O <= '0;
			PICKUP_PERCENT_O <= '0;
		end else begin
			PICKUP_O <= f_pick || g_pick;
			PICKUP_FLAGS_O.under <= f_pick && !freq_is_over;
			PICKUP_FLAGS_O.over <= f_pick && freq_is_over;
			PICKUP_FLAGS_O.grad <= g_pick;
			// The frequency stage is idle in chained modes, so the over trip stays low there.
			TRIP_O <= trip_gate && (f_trip || g_trip);
			TRIP_FLAGS_O.under <= trip_gate && f_trip && !freq_is_over;
			TRIP_FLAGS_O.over <= trip_gate && f_trip && freq_is_over;
			TRIP_FLAGS_O.grad <= trip_gate && g_trip;
			PICKUP_PERCENT_O.under <= freq_is_over ? 7'h00 : pf;
			PICKUP_PERCENT_O.over <= freq_is_over ? pf : 7'h00;
			PICKUP_PERCENT_O.grad <= pg;
			PICKUP_PERCENT_O.combined <= (pf > pg) ? pf : pg;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_chain_no_over: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$past(TRIP_MODE_I) == MODE_OVER_THEN_GRAD && TRIP_MODE_I == MODE_OVER_THEN_GRAD |=> !TRIP_FLAGS_O.over)
		else $error("over trip raised in chained mode");
	a_disabled_quiet: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		OPERATION_I != OPER_ENABLE |=> ##1 !PICKUP_O && !TRIP_O)
		else $error("outputs active while disabled");
	a_trip_block: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		blk && BLOCKING_MODE_I == BLK_TRIP |=> !TRIP_O)
		else $error("trip while trip output blocked");
	a_blockall_reset: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		blk && BLOCKING_MODE_I == BLK_ALL |=> f_op == '0 && g_op == '0)
		else $error("timers not reset under block all");
	a_freeze_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		freeze && active |=> f_op == $past(f_op) && g_op == $past(g_op))
		else $error("timer moved while frozen");
	a_trip_combined: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		TRIP_FLAGS_O != '0 |-> TRIP_O)
		else $error("criterion trip without combined trip");
	a_pick_combined: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		PICKUP_O == (PICKUP_FLAGS_O != '0))
		else $error("combined pickup mismatch");
	a_grad_trip_time: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		$rose(g_trip) |-> g_op >= GRADIENT_TRIP_DELAY_I)
		else $error("gradient trip before delay");
	a_pct_max: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		PICKUP_PERCENT_O.combined >= PICKUP_PERCENT_O.grad && PICKUP_PERCENT_O.combined <= PCT_FULL)
		else $error("combined percentage wrong");
	a_tick_period: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
		tick |=> !tick)
		else $error("tick not a single pulse");
endmodule // fpt_trip_logic

// ==== dv/fpt_meas_src.sv ====
/*
 * Model of the measurement source and binary input feeding the trip logic.
 * Assumes the bench commands values and this model presents them one clock later.
 */
`timescale 1ns/100ps
module fpt_meas_src #(
	parameter int FW = 16,
	parameter logic signed [FW-1:0] NOMINAL = 16'h03B6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Commanded values
	input wire logic signed [FW-1:0] freq_i,
	input wire logic signed [FW-1:0] grad_i,
	input wire logic block_i,
	// Towards the block
	output logic signed [FW-1:0] freq_o,
	output logic signed [FW-1:0] grad_o,
	output logic block_o
);
	// Nominal frequency in reset, so no criterion is met before the first real sample.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			freq_o <= NOMINAL;
			grad_o <= '0;
			block_o <= 1'b0;
		end else begin
			freq_o <= freq_i;
			grad_o <= grad_i;
			block_o <= block_i;
		end
	end
endmodule // fpt_meas_src

// ==== dv/tb.sv ====
/*
 * Self-checking bench for the frequency protection trip logic.
 * Assumes fpt_pkg and the measurement source model; 1 ms is shortened to 10 cycles.
 */
`timescale 1ns/100ps
module tb;
	import fpt_pkg::*;
	// --------------------------------
	// Signals
	// --------------------------------
	localparam logic signed [15:0] F_NOM = 16'h03B6;
	localparam logic signed [15:0] F_HI = 16'h041A;
	localparam logic signed [15:0] F_LO = 16'h0352;
	localparam logic signed [15:0] G_HI = 16'h0050;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic signed [15:0] f_set = F_NOM;
	logic signed [15:0] g_set = 16'h0000;
	logic blk_set = 1'b0;
	logic signed [15:0] freq;
	logic signed [15:0] grad;
	logic blk;
	logic [2:0] oper = OPER_ENABLE;
	logic [2:0] mode = MODE_OVER;
	logic [1:0] bmode = BLK_FREEZE;
	logic [TW-1:0] ftd = 18'h00003;
	logic [TW-1:0] gtd = 18'h00006;
	logic [TW-1:0] frd = 18'h00000;
	logic [TW-1:0] grd = 18'h00002;
	logic pk;
	logic tr;
	fpt_flags_t pkf;
	fpt_flags_t trf;
	fpt_pct_t pct;
	int miscompares = 0;
	int n_checks = 0;
	initial forever #10 clk = ~clk;
	fpt_meas_src u_src (.clk_i(clk), .rst_n_i(rst_n), .freq_i(f_set), .grad_i(g_set), .block_i(blk_set),
		.freq_o(freq), .grad_o(grad), .block_o(blk));
	fpt_trip_logic #(.FW(16), .TICK_DIV(10)) u_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
		.FREQUENCY_IN_I(freq), .FREQUENCY_GRADIENT_IN_I(grad), .OPERATION_I(oper), .TRIP_MODE_I(mode),
		.BLOCKING_MODE_I(bmode), .OVERFREQ_PICKUP_I(16'h03E8), .UNDERFREQ_PICKUP_I(16'h0384),
		.GRADIENT_PICKUP_I(16'h0032), .FREQUENCY_TRIP_DELAY_I(ftd), .GRADIENT_TRIP_DELAY_I(gtd),
		.FREQUENCY_RESET_DELAY_I(frd), .GRADIENT_RESET_DELAY_I(grd), .BLOCK_I(blk),
		.PICKUP_O(pk), .PICKUP_FLAGS_O(pkf), .TRIP_O(tr), .TRIP_FLAGS_O(trf), .PICKUP_PERCENT_O(pct));
	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic bad(input string s, input int e, input logic [6:0] g);
		miscompares++;
		$display("[FAIL] %s expected %0d seen %0d", s, e, g);
	endtask
	task automatic chk_bit(input string s, input logic e, input logic g);
		n_checks++;
		if (g !== e) bad(s, e, {6'h00, g});
	endtask
	task automatic chk_pct(input string s, input logic [6:0] e, input logic [6:0] g);
		n_checks++;
		if (g !== e) bad(s, e, g);
	endtask
	task automatic chk_rng(input string s, input int lo, input int hi, input logic [6:0] g);
		n_checks++;
		if ((g >= lo && g <= hi) !== 1'b1) bad(s, lo, g);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Waits for pickup (sel 0) or trip (sel 1), returning the cycles spent.
	task automatic wait_hi(input int sel, input int lim, output int n);
		n = 0;
		while ((sel ? tr : pk) !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic start(input logic [2:0] m, input logic signed [15:0] f, input logic signed [15:0] g);
		int n;
		@(posedge clk);
		mode <= m;
		f_set <= f;
		g_set <= g;
		wait_hi(0, 20, n);
	endtask
	task automatic idle;
		@(posedge clk);
		f_set <= F_NOM;
		g_set <= 16'h0000;
		blk_set <= 1'b0;
		cyc(40);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic s_modes;
		logic [7:0] exp = 8'hDA;
		for (int m = 1; m <= 7; m++) begin
			start(3'(m), F_LO, G_HI);
			cyc(3);
			chk_bit("mode pickup", exp[m], pk);
			idle();
		end
	endtask
	task automatic s_chain;
		int n;
		start(MODE_OVER_THEN_GRAD, F_NOM, G_HI);
		chk_bit("pickup gated", 1'b0, pk);
		start(MODE_OVER_THEN_GRAD, F_HI, G_HI);
		chk_bit("grad pickup", 1'b1, pkf.grad);
		wait_hi(1, 100, n);
		chk_bit("grad trip", 1'b1, trf.grad);
		chk_rng("trip delay", 50, 60, 7'(n));
		chk_bit("over trip", 1'b0, trf.over);
		idle();
		start(MODE_OVER_THEN_GRAD, F_HI, G_HI);
		cyc(20);
		g_set <= 16'h0000;
		cyc(10);
		chk_bit("pickup held", 1'b1, pk);
		cyc(25);
		chk_bit("pickup dropped", 1'b0, pk);
		idle();
	endtask
	task automatic s_or;
		int n;
		start(MODE_OVER_OR_GRAD, F_HI, 16'h0000);
		chk_bit("over pickup", 1'b1, pkf.over);
		chk_bit("grad pickup", 1'b0, pkf.grad);
		g_set <= G_HI;
		wait_hi(1, 100, n);
		chk_bit("over trip", 1'b1, trf.over);
		chk_bit("grad trip", 1'b0, trf.grad);
		f_set <= F_NOM;
		g_set <= 16'h0000;
		cyc(6);
		chk_bit("over dropped", 1'b0, pkf.over);
		idle();
		start(MODE_UNDER_OR_GRAD, F_NOM, G_HI);
		chk_bit("under pickup", 1'b0, pkf.under);
		g_set <= 16'h0000;
		cyc(10);
		chk_bit("grad held", 1'b1, pkf.grad);
		cyc(25);
		chk_bit("grad dropped", 1'b0, pkf.grad);
		idle();
	endtask
	task automatic s_under;
		int n;
		start(MODE_UNDER_OR_GRAD, F_LO, 16'h0000);
		wait_hi(1, 100, n);
		chk_bit("under trip", 1'b1, trf.under);
		chk_pct("under percent", 7'h64, pct.under);
		frd <= 18'h00002;
		f_set <= F_NOM;
		cyc(10);
		chk_bit("under held", 1'b1, pkf.under);
		cyc(25);
		chk_bit("under dropped", 1'b0, pkf.under);
		frd <= 18'h00000;
		idle();
	endtask
	task automatic s_pct;
		start(MODE_OVER, F_HI, 16'h0000);
		cyc(15);
		chk_rng("over percent", 30, 70, pct.over);
		chk_rng("combined percent", 30, 70, pct.combined);
		chk_pct("grad percent", 7'h00, pct.grad);
		idle();
	endtask
	task automatic s_freeze;
		int n;
		bmode <= BLK_FREEZE;
		start(MODE_OVER, F_HI, 16'h0000);
		blk_set <= 1'b1;
		cyc(60);
		chk_bit("frozen trip", 1'b0, tr);
		blk_set <= 1'b0;
		wait_hi(1, 40, n);
		blk_set <= 1'b1;
		cyc(10);
		chk_bit("trip kept", 1'b1, tr);
		idle();
	endtask
	task automatic s_blkall;
		int n;
		bmode <= BLK_ALL;
		start(MODE_OVER, F_HI, 16'h0000);
		cyc(15);
		blk_set <= 1'b1;
		cyc(5);
		chk_bit("blocked pickup", 1'b0, pk);
		chk_pct("blocked percent", 7'h00, pct.over);
		blk_set <= 1'b0;
		wait_hi(0, 20, n);
		wait_hi(1, 100, n);
		chk_rng("restart delay", 20, 45, 7'(n));
		idle();
	endtask
	task automatic s_blktrip;
		int n;
		bmode <= BLK_TRIP;
		start(MODE_OVER, F_HI, 16'h0000);
		blk_set <= 1'b1;
		cyc(60);
		chk_bit("trip masked", 1'b0, tr);
		chk_bit("pickup kept", 1'b1, pk);
		blk_set <= 1'b0;
		wait_hi(1, 6, n);
		chk_bit("trip released", 1'b1, tr);
		idle();
	endtask
	task automatic s_disable;
		@(posedge clk);
		oper <= OPER_DISABLE;
		start(MODE_OVER_OR_GRAD, F_HI, G_HI);
		cyc(60);
		chk_bit("disabled pickup", 1'b0, pk);
		chk_bit("disabled trip", 1'b0, tr);
		oper <= OPER_ENABLE;
		idle();
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		cyc(5);
		s_modes();
		s_chain();
		s_or();
		s_under();
		s_pct();
		s_freeze();
		s_blkall();
		s_blktrip();
		s_disable();
		end_of_test();
	end
	// The run needs under two thousand cycles; allow twenty thousand.
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
endmodule // tb
